// ===== bench/spi_host_model.sv
// Host master of the video serial stream: clocks a given number of packet bytes in clock-idle-high mode.
// Assumes the bench calls its tasks at falling mclk edges, one task at a time.
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic mclk,
    output logic      sck,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    logic [7:0] pkt [0:243];
    // Idle levels; single master on a point-to-point link
    initial begin
        sck  = 1'b1; // Clock idles high
        csN  = 1'b1;
        mosi = 1'b0; // Unused data-in held low
    end
    // 800 ns period: far below the ceiling, fast enough for a frame
    task automatic read_packet(input int n);
        csN = 1'b0;
        for (int b = 0; b < n * 8; b++) begin
            repeat (4) @(negedge mclk);
            sck = 1'b0;
            repeat (4) @(negedge mclk);
            sck = 1'b1;
            pkt[b / 8] = {pkt[b / 8][6:0], miso}; // Sample on rising edge
        end
    endtask
    // Select high, clock parked high: forces a resync
    task automatic idle(input int cycles);
        csN = 1'b1;
        repeat (cycles) @(negedge mclk);
    endtask
endmodule // spi_host_model

// ===== bench/video_packet_tx_tb.sv
// Testbench of the video packet transmitter: pushes lines, reads packets as host.
// Assumes the host model in spi_host_model.sv and a 10 MHz core clock.
`timescale 1ns/1ps
module video_packet_tx_tb;
    import video_stream_pkg::*;
    logic             mclk = 1'b0;
    logic             arst_n = 1'b0;
    logic             sck, csN, miso, pixReady, inSync;
    logic             pixFirst = 1'b0;
    logic             pixValid = 1'b0;
    logic [PIX_W-1:0] pixData = '0;
    logic             colourFormat = 1'b0;
    logic             telemetryEnable = 1'b0;
    logic             gainControl = 1'b0;
    logic             linearOutput = 1'b0;
    logic             off = 1'b0;
    logic [15:0]      crc;
    int               error_cnt, comparisons, cycles;
    video_packet_tx #(.SYNC_IDLE_CNT(200), .INTRA_CNT(20000), .FIFO_DEPTH(8))
        video_packet_tx_inst (.mclk(mclk), .arst_n(arst_n), .sck(sck), .csN(csN),
        .miso(miso), .pixData(pixData), .pixFirst(pixFirst), .pixValid(pixValid),
        .pixReady(pixReady), .colourFormat(colourFormat), .telemetryEnable(telemetryEnable),
        .telemetryFooter(off), .gainControl(gainControl), .linearOutput(linearOutput),
        .inSync(inSync));
    spi_host_model spi_host_model_inst (.mclk(mclk), .sck(sck), .csN(csN), .mosi(),
        .miso(miso));
    always #50 mclk = ~mclk;
    // Hang guard, set just above the longest clean run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 97000) begin
            error_cnt++;
            give_verdict();
        end
    end
    function automatic logic [7:0] rx(input int i);
        return spi_host_model_inst.pkt[i];
    endfunction
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) r = r[15] ? {r[14:0], 1'b0} ^ CRC_POLY : {r[14:0], 1'b0};
        return r;
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Pushes 80 words, holding each until pixReady accepts it
    task automatic push_line(input logic first, input logic [PIX_W-1:0] base);
        int i;
        i = 0;
        while (i < 80) begin
            @(negedge mclk);
            pixValid = 1'b1;
            pixData  = base + PIX_W'(i);
            pixFirst = first && (i == 0);
            if (pixReady === 1'b1) i++;
        end
        @(negedge mclk);
        pixValid = 1'b0;
    endtask
    // Reads one video packet; pixel k is expected as first + k, two or three bytes each
    task automatic read_video(input int id, input logic [PIX_W-1:0] first, input logic col);
        logic [PIX_W-1:0] v;
        spi_host_model_inst.read_packet(col ? HDR_BYTES + LINE_PIXELS * COL_BYTES_PX
                                            : HDR_BYTES + LINE_PIXELS * RAW_BYTES_PX);
        check("packet id", {rx(0), rx(1)}, 16'(id));
        crc = crc_step(crc_step(CRC_INIT, 8'(id >> 8)), 8'(id));
        crc = crc_step(crc_step(crc, 8'h00), 8'h00);
        for (int k = 0; k < 80; k++) begin
            v = first + PIX_W'(k);
            if (col) begin
                crc = crc_step(crc, v[23:16]);
                check("red green", {rx(4 + 3 * k), rx(5 + 3 * k)}, v[23:8]);
                check("blue", 16'(rx(6 + 3 * k)), 16'(v[7:0]));
            end else begin
                check("pixel", {rx(4 + 2 * k), rx(5 + 2 * k)}, v[15:0]);
            end
            crc = crc_step(crc_step(crc, v[15:8]), v[7:0]);
        end
        check("crc", {rx(2), rx(3)}, crc);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        // No frame yet: discard packet
        spi_host_model_inst.read_packet(164);
        check("discard id", {rx(0), rx(1)}, 16'h0f00);
        $display("test discard done");
        // Two raw lines with top bits set, masked to 14 bits on the wire
        push_line(1'b1, 24'h00c000);
        push_line(1'b0, 24'hffc080);
        repeat (20) @(negedge mclk);
        // Packets 0 and 1 of the frame are read in turn
        for (int p = 0; p < 2; p++) begin
            read_video(p, PIX_W'(p * 128), 1'b0);
        end
        check("in sync", 16'(inSync), 16'h0001);
        $display("test video lines done");
        // Idle beyond the timeout, then discards again
        spi_host_model_inst.idle(300);
        check("sync lost", 16'(inSync), 16'h0000);
        spi_host_model_inst.read_packet(164);
        check("restart id", {rx(0), rx(1)}, 16'h0f00);
        $display("test resync done");
        // Gain line then linear line, mode switched once the line is buffered
        gainControl = 1'b1;
        push_line(1'b1, 24'h00c100);
        repeat (30) @(negedge mclk);
        gainControl  = 1'b0;
        linearOutput = 1'b1;
        push_line(1'b0, 24'h12c080);
        repeat (30) @(negedge mclk);
        read_video(0, 24'h000000, 1'b0);
        read_video(1, 24'h00c080, 1'b0);
        $display("test gain and linear done");
        // Packet cut after its header, then resync before the telemetry change
        spi_host_model_inst.read_packet(4);
        check("cut id", {rx(0), rx(1)}, 16'h0f00);
        spi_host_model_inst.idle(300);
        linearOutput    = 1'b0;
        telemetryEnable = 1'b1;
        push_line(1'b1, 24'h00c000);
        repeat (30) @(negedge mclk);
        read_video(0, 24'h00c000, 1'b0); // Telemetry line left unmasked
        $display("test cut packet and telemetry done");
        // Resync, then one colour line; telemetry is ignored in this format
        spi_host_model_inst.idle(300);
        colourFormat = 1'b1;
        push_line(1'b1, 24'h102030);
        repeat (30) @(negedge mclk);
        read_video(0, 24'h102030, 1'b1);
        $display("test colour done");
        give_verdict();
    end
endmodule // video_packet_tx_tb

// ===== inc/video_stream_pkg.sv
// Constants, field layouts and timing for the video serial stream transmitter.
// Assumes a single 10 MHz core clock; every cycle count below derives from it.
package video_stream_pkg;

    // Core clock and protocol timing
    localparam int CLK_HZ           = 10_000_000;
    localparam int SYNC_IDLE_MS     = 185;
    localparam int SYNC_IDLE_CYCLES = SYNC_IDLE_MS * (CLK_HZ / 1000);
    localparam int LINE_PERIOD_US   = 500;
    localparam int INTRA_LINES      = 3;
    localparam int INTRA_CYCLES     = INTRA_LINES * LINE_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int TIMER_W          = 24;

    // Packet geometry
    localparam int HDR_BYTES     = 4;
    localparam int RAW_PAYLOAD   = 160;
    localparam int COL_PAYLOAD   = 240;
    localparam int RAW_BYTES_PX  = 2;
    localparam int COL_BYTES_PX  = 3;
    localparam int LINE_PIXELS   = 80;
    localparam int SENSOR_ROWS   = 60;
    localparam int TELEM_LINES   = 3;
    localparam int PKTS_NO_TELEM = 60;
    localparam int PKTS_TELEM    = 63;
    localparam int BYTE_IDX_W    = 8;
    localparam int PIX_IDX_W     = 7;
    localparam int PKT_NUM_W     = 12;
    localparam int PIX_W         = 24;

    // Header fields
    localparam logic [3:0]  ID_RESERVED    = 4'h0;
    localparam logic [3:0]  DISCARD_NIBBLE = 4'hf;
    localparam logic [15:0] CRC_POLY       = 16'h1021;
    localparam logic [15:0] CRC_INIT       = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;

    // Pixel word masks for the raw format
    localparam logic [PIX_W-1:0] MASK_FULL  = 24'hffffff;
    localparam logic [PIX_W-1:0] MASK_RAW_PIXEL_FORMAT = 24'h003fff;
    localparam logic [PIX_W-1:0] MASK_GAIN  = 24'h0000ff;

    // Line fill sequencer
    typedef enum logic [2:0] {
        FILL_IDLE = 3'b001,
        FILL_RUN  = 3'b010,
        FILL_DONE = 3'b100
    } fill_state_t;

endpackage

// ===== src/pixel_fifo.sv
// Small synchronous FIFO carrying pixel words into the packet transmitter.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;

    wire              doWrite    = inValid && inReady;
    wire              doRead     = outValid && outReady;
    wire [AW:0]       next_count = count + (AW + 1)'(doWrite) - (AW + 1)'(doRead);

    assign outData = mem[rdPtr];

    // Storage
    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and registered full/empty flags
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr    <= '0;
            rdPtr    <= '0;
            count    <= '0;
            inReady  <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count    <= next_count;
            inReady  <= (next_count != FULL_COUNT);
            outValid <= (next_count != '0);
        end
    end

endmodule // pixel_fifo

// ===== src/video_packet_tx.sv
// Slave transmitter of the video serial stream: buffers lines, frames packets,
// shifts them out on the data-out pin in clock-idle-high mode.
// Assumes the serial clock and select are asynchronous pins, far slower than mclk.
`timescale 1ns/1ps

// Functional notes
// - Exactly one master and one slave share the video link.
// - Clock idles high; device changes data on falling edge, host samples rising.
// - Multi-byte quantities go out most significant byte first.
// - Packet is 4-byte header plus 160 or 240 payload bytes.
// - Frame holds 60 packets, 63 with telemetry; no telemetry in colour format.
// - Header holds 16-bit id (12-bit packet number, reserved top nibble) then CRC.
// - Packet number restarts at zero each frame and increments per packet.
// - Header CRC is 16 bits with polynomial x16+x12+x5+1.
// - CRC covers whole packet with reserved nibble and CRC field taken as zero.
// - Discard packets go out before sync and whenever no line is ready.
// - Discard id has bits 11:8 all ones; same length as video packets.
// - Raw payload carries 80 two-byte pixels in order.
// - Raw words zero top two bits, linear uses all, gain zeroes top byte.
// - Colour payload carries 80 pixels as red, green, blue bytes.
// - Telemetry lines sit in packets 0-2 as header or 60-62 as footer.
// - Each video packet carries exactly one whole line.
// - Host may stop between frames; continued clocking yields discard packets.
// - Select high with clock idle beyond 185 ms resets stream to discards.
// - Packet not finished within three line periods drops synchronisation.
module video_packet_tx
    import video_stream_pkg::*;
#(
    parameter int SYNC_IDLE_CNT = video_stream_pkg::SYNC_IDLE_CYCLES,
    parameter int INTRA_CNT     = video_stream_pkg::INTRA_CYCLES,
    parameter int FIFO_DEPTH    = 8
) (
    input  wire logic                                mclk,
    input  wire logic                                arst_n,
    input  wire logic                                sck,
    input  wire logic                                csN,
    output logic                                     miso,
    input  wire logic [video_stream_pkg::PIX_W-1:0]  pixData,
    input  wire logic                                pixFirst,
    input  wire logic                                pixValid,
    output logic                                     pixReady,
    input  wire logic                                colourFormat,
    input  wire logic                                telemetryEnable,
    input  wire logic                                telemetryFooter,
    input  wire logic                                gainControl,
    input  wire logic                                linearOutput,
    output logic                                     inSync
);
    import video_stream_pkg::*;

    localparam int FW = PIX_W + 1;

    // Pin synchronisers and edge detect; one host owns the pins
    logic sckMeta, sckS, sckD, csMeta, csS;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sckMeta <= 1'b1;
            sckS    <= 1'b1;
            sckD    <= 1'b1;
            csMeta  <= 1'b1;
            csS     <= 1'b1;
        end else begin
            sckMeta <= sck;
            sckS    <= sckMeta;
            sckD    <= sckS;
            csMeta  <= csN;
            csS     <= csMeta;
        end
    end
    wire sckFall = sckD && !sckS;
    wire shiftEn = sckFall && !csS;   // Clock edges with select high are ignored

    // Pixel FIFO
    logic [FW-1:0] headWord;
    logic          headValid;
    logic          headPop;
    pixel_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .inData   ({pixFirst, pixData}),
        .inValid  (pixValid),
        .inReady  (pixReady),
        .outData  (headWord),
        .outValid (headValid),
        .outReady (headPop)
    );

    // CRC over one byte, MSB first
    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    // Byte of a pixel word, big-endian within the pixel
    function automatic logic [7:0] pixByte(input logic [PIX_W-1:0] w, input logic [1:0] sub,
                                           input logic colour);
        logic [1:0] pos;
        pos = colour ? sub : sub + 2'd1;
        case (pos)
            2'd0:    return w[23:16];
            2'd1:    return w[15:8];
            default: return w[7:0];
        endcase
    endfunction

    // Format-dependent geometry
    wire                  telOn      = telemetryEnable && !colourFormat;
    wire [BYTE_IDX_W-1:0] lastByte   = colourFormat ? BYTE_IDX_W'(HDR_BYTES + COL_PAYLOAD - 1)
                                                    : BYTE_IDX_W'(HDR_BYTES + RAW_PAYLOAD - 1);
    wire [1:0]            lastSub    = colourFormat ? 2'(COL_BYTES_PX - 1) : 2'(RAW_BYTES_PX - 1);
    wire [PKT_NUM_W-1:0]  pktsFrame  = telOn ? PKT_NUM_W'(PKTS_TELEM) : PKT_NUM_W'(PKTS_NO_TELEM);

    // Shared state between fill and transmit sides
    logic [PIX_W-1:0]     lineMem [0:(2 << PIX_IDX_W)-1];
    logic [1:0]           bankFull;
    logic [PKT_NUM_W-1:0] bankPkt [0:1];
    logic [15:0]          bankCrc [0:1];
    logic                 fillBank, txBank;
    logic                 flush;
    logic                 txRelease;

    // Fill side registers
    fill_state_t          fillState;
    logic [BYTE_IDX_W-1:0] fillByte;
    logic [1:0]           fillSub;
    logic [PIX_IDX_W-1:0] fillPix;
    logic [PKT_NUM_W-1:0] fillPkt, curPkt;
    logic [15:0]          fillCrc;
    logic                 fillDrop, waitFrame;

    // Fill decode: line start, header bytes, masked pixel bytes
    wire headFirst  = headWord[PIX_W];
    wire bankFree   = !bankFull[fillBank];
    wire lineStart  = (fillState == FILL_IDLE) && bankFree && headValid;
    wire [PKT_NUM_W-1:0] startPkt = headFirst ? '0 : fillPkt;   // Restart at zero
    wire isTelem    = telOn && (telemetryFooter ? (curPkt >= PKT_NUM_W'(SENSOR_ROWS))
                                                : (curPkt < PKT_NUM_W'(TELEM_LINES)));
    wire [PIX_W-1:0] pixMask = (colourFormat || isTelem) ? MASK_FULL :
                               gainControl                ? MASK_GAIN :
                               linearOutput               ? MASK_FULL : MASK_RAW_PIXEL_FORMAT;
    wire [PIX_W-1:0] maskedPix = headWord[PIX_W-1:0] & pixMask;
    wire inHeader   = fillByte < BYTE_IDX_W'(HDR_BYTES);
    // Reserved nibble and CRC field enter the CRC as zero
    wire [7:0] fillHdrByte = (fillByte == '0) ? {ID_RESERVED, curPkt[11:8]} :
                             (fillByte == 8'h01) ? curPkt[7:0] : ZERO_BYTE;
    wire [7:0] fillCur  = inHeader ? fillHdrByte : pixByte(maskedPix, fillSub, colourFormat);
    wire fillStep       = (fillState == FILL_RUN) && (inHeader || headValid);
    wire pixDone        = fillStep && !inHeader && (fillSub == lastSub);
    assign headPop      = pixDone;
    wire [PKT_NUM_W-1:0] next_fillPkt = (curPkt == pktsFrame - 1'b1) ? '0 : curPkt + 1'b1;

    // Line buffer write, one whole line per bank
    always_ff @(posedge mclk) begin
        if (pixDone) begin
            lineMem[{fillBank, fillPix}] <= maskedPix;
        end
    end

    // Fill sequencer: header bytes then payload, CRC accumulated per byte
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fillState <= FILL_IDLE;
            fillByte  <= '0;
            fillSub   <= '0;
            fillPix   <= '0;
            fillPkt   <= '0;
            curPkt    <= '0;
            fillCrc   <= CRC_INIT;
            fillDrop  <= 1'b1;
            waitFrame <= 1'b1;
            fillBank  <= 1'b0;
            bankPkt[0] <= '0;
            bankPkt[1] <= '0;
            bankCrc[0] <= CRC_INIT;
            bankCrc[1] <= CRC_INIT;
        end else begin
            case (fillState)
                FILL_IDLE: begin
                    if (lineStart) begin
                        fillDrop  <= waitFrame && !headFirst;   // Hold off until frame start
                        waitFrame <= waitFrame && !headFirst;
                        curPkt    <= startPkt;
                        fillCrc   <= CRC_INIT;
                        fillByte  <= '0;
                        fillSub   <= '0;
                        fillPix   <= '0;
                        fillState <= FILL_RUN;
                    end
                end
                FILL_RUN: begin
                    if (fillStep) begin
                        fillCrc <= crcByte(fillCrc, fillCur);
                        if (fillByte == lastByte) begin
                            fillState <= FILL_DONE;
                        end
                        fillByte <= fillByte + 1'b1;
                        if (!inHeader) begin
                            fillSub <= pixDone ? '0 : fillSub + 1'b1;
                            fillPix <= pixDone ? fillPix + 1'b1 : fillPix;
                        end
                    end
                end
                FILL_DONE: begin
                    if (!fillDrop && !flush) begin
                        bankPkt[fillBank] <= curPkt;
                        bankCrc[fillBank] <= fillCrc;
                        fillBank          <= !fillBank;
                    end
                    fillPkt   <= next_fillPkt;   // Increment per packet
                    fillState <= FILL_IDLE;
                end
                default: fillState <= FILL_IDLE;
            endcase
            if (flush) begin
                fillDrop  <= 1'b1;
                waitFrame <= 1'b1;
            end
        end
    end

    // Bank ownership: fill sets, transmit releases, timeout flushes
    wire fillCommit = (fillState == FILL_DONE) && !fillDrop && !flush;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bankFull <= '0;
        end else if (flush) begin
            bankFull <= '0;
        end else begin
            if (txRelease) begin
                bankFull[txBank] <= 1'b0;
            end
            if (fillCommit) begin
                bankFull[fillBank] <= 1'b1;
            end
        end
    end

    // Transmit side registers
    logic [BYTE_IDX_W-1:0] txByte;
    logic [2:0]            txBit;
    logic [1:0]            txSub;
    logic [PIX_IDX_W-1:0]  txPix;
    logic                  txVideo;

    // Transmit decode: discard or video chosen at the first bit
    wire atStart    = (txByte == '0) && (txBit == '0);
    wire txVideoNow = atStart ? bankFull[txBank] : txVideo;
    wire [PKT_NUM_W-1:0] txPkt = bankPkt[txBank];
    wire [15:0]          txCrc = bankCrc[txBank];
    wire [7:0] vidHdr = (txByte == '0)    ? {ID_RESERVED, txPkt[11:8]} :
                        (txByte == 8'h01) ? txPkt[7:0] :
                        (txByte == 8'h02) ? txCrc[15:8] : txCrc[7:0];
    wire [7:0] disHdr = (txByte == '0) ? {ID_RESERVED, DISCARD_NIBBLE} : ZERO_BYTE;
    wire txInHdr      = txByte < BYTE_IDX_W'(HDR_BYTES);
    wire [7:0] txCur  = !txVideoNow ? (txInHdr ? disHdr : ZERO_BYTE) :
                        txInHdr     ? vidHdr :
                        pixByte(lineMem[{txBank, txPix}], txSub, colourFormat);
    wire byteEnd      = shiftEn && (txBit == 3'd7);
    wire pktEnd       = byteEnd && (txByte == lastByte);
    assign txRelease  = pktEnd && txVideoNow;

    // Shift register: one bit per falling clock edge, MSB first
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            miso    <= 1'b1;
            txByte  <= '0;
            txBit   <= '0;
            txSub   <= '0;
            txPix   <= '0;
            txVideo <= 1'b0;
            txBank  <= 1'b0;
        end else if (flush) begin
            txByte  <= '0;
            txBit   <= '0;
            txSub   <= '0;
            txPix   <= '0;
            txVideo <= 1'b0;
            txBank  <= fillBank;
        end else if (shiftEn) begin
            miso  <= txCur[3'd7 - txBit];
            txBit <= txBit + 1'b1;
            if (atStart) begin
                txVideo <= bankFull[txBank];
            end
            if (pktEnd) begin
                txByte <= '0;               // Fixed length per format
                txSub  <= '0;
                txPix  <= '0;
                if (txVideoNow) begin
                    txBank <= !txBank;
                end
            end else if (byteEnd) begin
                txByte <= txByte + 1'b1;
                if (!txInHdr) begin
                    txSub <= (txSub == lastSub) ? '0 : txSub + 1'b1;
                    txPix <= (txSub == lastSub) ? txPix + 1'b1 : txPix;
                end
            end
        end
    end

    // Timeouts: idle with select high, and an overlong packet
    logic [TIMER_W-1:0] idleCnt, intraCnt;
    wire idleExpire  = (idleCnt == TIMER_W'(SYNC_IDLE_CNT - 1));
    wire intraExpire = (intraCnt == TIMER_W'(INTRA_CNT - 1)) && !atStart;
    assign flush     = idleExpire || intraExpire;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            idleCnt  <= '0;
            intraCnt <= '0;
        end else begin
            if (!csS || !sckS) begin
                idleCnt <= '0;
            end else if (idleCnt != TIMER_W'(SYNC_IDLE_CNT)) begin
                idleCnt <= idleCnt + 1'b1;
            end
            if (atStart || flush) begin
                intraCnt <= '0;
            end else begin
                intraCnt <= intraCnt + 1'b1;
            end
        end
    end

    // Sync status: set by the first video packet, lost on timeout
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inSync <= 1'b0;
        end else if (flush) begin
            inSync <= 1'b0;
        end else if (shiftEn && atStart && bankFull[txBank]) begin
            inSync <= 1'b1;
        end
    end

    // Checks
    a_miso_fall_only: assert property (@(posedge mclk) disable iff (!arst_n)
        !$stable(miso) |-> $past(shiftEn)) else $error("data-out changed off a falling edge");
    a_cs_freezes_pos: assert property (@(posedge mclk) disable iff (!arst_n)
        csS && !flush |=> $stable(txByte) && $stable(txBit))
        else $error("bit position moved while select high");
    a_msb_first_out: assert property (@(posedge mclk) disable iff (!arst_n)
        shiftEn && !flush |=> miso == $past(txCur[3'd7 - txBit]))
        else $error("wrong bit shifted out");
    a_discard_nibble: assert property (@(posedge mclk) disable iff (!arst_n)
        (txByte == '0) && !txVideoNow |-> txCur[3:0] == DISCARD_NIBBLE)
        else $error("discard id nibble not all ones");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        (txByte == '0) && txVideoNow |-> txCur == {ID_RESERVED, txPkt[11:8]})
        else $error("video id reserved bits not zero");
    a_frame_restart: assert property (@(posedge mclk) disable iff (!arst_n)
        lineStart && headFirst |=> curPkt == '0) else $error("packet number not restarted");
    a_pkt_in_frame: assert property (@(posedge mclk) disable iff (!arst_n)
        fillState == FILL_RUN |-> curPkt < pktsFrame) else $error("packet number beyond frame");
    a_gain_top_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        pixDone && gainControl && !colourFormat && !isTelem |-> maskedPix[15:8] == 8'h00)
        else $error("gain word top byte not zero");
    a_packet_length: assert property (@(posedge mclk) disable iff (!arst_n)
        txByte <= lastByte) else $error("packet longer than format allows");
    a_idle_resets: assert property (@(posedge mclk) disable iff (!arst_n)
        idleExpire |=> atStart && !inSync && bankFull == '0)
        else $error("idle timeout did not restart stream");
    a_intra_timeout: assert property (@(posedge mclk) disable iff (!arst_n)
        intraExpire |=> ##[0:2] atStart && !inSync) else $error("packet timeout not taken");

endmodule // video_packet_tx
